/* File: verilog/imucc_ctrl.sv */
// Calibration, command and serial register control of the inertial sensor
//
// What this block does
// - Acceleration words: 14-bit two's complement
// - Temperature words: 12-bit two's complement, zero 25C
// - Auxiliary input words: 12-bit offset binary
// - Gyro offset, 13 bits, added to rate
// - Accel offset, 12 bits, added to acceleration
// - Autonull: negate gyro, zero data, save flash
// - Precision autonull: 30 s average, zero, save
// - Factory restore: clear offsets, zero, save flash
// - Misc bit 7 enables gyro acceleration compensation
// - Command bits self-clear after their operation ends
// - Software reset reloads controls from flash first
// - Reading command register starts a burst read
// - Flash update copies nonvolatile controls to flash
// - DAC latch moves holding value to output
// - Sample period is time base times increment+1
// - Period value 0x0A or more selects low power
// - Indefinite sleep until chip select falls
// - Timed sleep lasts count times half second
// - New-data and error flags in each output word
// - Burst shifts output words with one-clock gaps
`timescale 1ns/100ps
`default_nettype none
module imucc_ctrl #(
	parameter logic [31:0] TB_FAST = 32'(imucc_pkg::TB_FAST_CYC),
	parameter logic [31:0] TB_SLOW = 32'(imucc_pkg::TB_SLOW_CYC),
	parameter logic [31:0] FLASH_CYC = 32'(imucc_pkg::FLASH_CYC),
	parameter logic [31:0] PREC_CYC = 32'(imucc_pkg::PREC_CYC),
	parameter logic [31:0] SLEEP_UNIT = 32'(imucc_pkg::SLEEP_UNIT_CYC),
	parameter logic [15:0] PROD_ID = 16'h5A5A // Arbitrary identification value
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic spi_cs_n, // Chip select, active low
	input wire logic spi_sclk, // Serial clock, idles high
	input wire logic spi_mosi, // Serial data in
	output logic spi_miso, // Serial data out
	input wire imucc_pkg::imucc_raw_t raw, // Raw sensor samples
	input wire logic [15:0] diag_flags, // Diagnostic status flags
	output logic sample_tick, // Sample strobe to sensing core
	output logic [11:0] dac_value, // Latched DAC input value
	output logic low_power, // Low power mode
	output logic sleeping // Device asleep
);
	imucc_pkg::imucc_state_t state_r;
	imucc_pkg::imucc_nv_t nv_img, nv_q;
	logic sclk_q_r, cs_q_r, burst_r, save_req_r, slp_inf_r, flash_done, tick;
	logic [4:0] bit_cnt_r;
	logic [15:0] rx_r, tx_r, tx_next_r, misc_r, prd_r, word, rd_data;
	logic [3:0] burst_idx_r;
	logic [13:0] out_r [0:10];
	logic [10:0] nd_r, nd_clr;
	logic [15:0] offs_r [0:5];
	logic [15:0] avg_r [0:2];
	logic [11:0] dac_r;
	logic [7:0] cmd_r, cmd_clr, mask_r, sleep_control_r, sleep_left_r;
	logic [31:0] cnt_r;
	logic rise, fall, cs_fall, frame_done, is_wr, is_rd;
	logic go_boot, go_restore, go_null, go_prec, go_flash, go_sleep, prec_done;
	logic zero_out, fsm_done;
	logic [6:0] wa;
	logic [7:0] wd;

	// Rate plus fine offset (quarter-count) less the acceleration term
	function automatic logic [13:0] gyro_adj(input logic [13:0] r, input logic [15:0] off,
			input logic [13:0] acc, input logic en);
		logic [16:0] s;
		s = {{1{r[13]}}, r, 2'b00} + {{4{off[12]}}, off[12:0]};
		if (en) begin
			s = s - {{5{acc[13]}}, acc[13:2]};
		end
		return s[15:2];
	endfunction : gyro_adj

	// Negated value truncated to the 13-bit offset field
	function automatic logic [15:0] neg_off(input logic [15:0] v);
		logic [15:0] n;
		n = 16'h0000 - v;
		return n & imucc_pkg::GYRO_OFF_MASK;
	endfunction : neg_off

	// Output word with new-data and error flags in the top bits
	function automatic logic [15:0] out_word(input int i);
		return {nd_r[i], |diag_flags, out_r[i]};
	endfunction : out_word

	// Serial edge and frame decode; inputs are synchronous to clk_sys
	assign rise = spi_sclk & ~sclk_q_r & ~spi_cs_n;
	assign fall = ~spi_sclk & sclk_q_r & ~spi_cs_n;
	assign cs_fall = ~spi_cs_n & cs_q_r;
	assign frame_done = rise & (bit_cnt_r == 5'd15);
	assign word = {rx_r[14:0], spi_mosi};
	assign wa = word[14:8];
	assign wd = word[7:0];
	assign is_wr = frame_done & word[15] & ~burst_r;
	assign is_rd = frame_done & ~word[15] & ~burst_r;

	// Register read multiplexer; write-only registers read zero
	always_comb begin
		rd_data = 16'h0000;
		if (wa >= imucc_pkg::ADDR_SUPPLY && wa <= imucc_pkg::ADDR_AUX_ADC + 7'h01) begin
			rd_data = out_word(int'(wa - imucc_pkg::ADDR_SUPPLY) / 2);
		end else if (wa >= imucc_pkg::ADDR_GYRO_OFF && wa <= imucc_pkg::ADDR_ACCL_OFF_END) begin
			rd_data = offs_r[int'(wa - imucc_pkg::ADDR_GYRO_OFF) / 2];
		end else begin
			case (wa[6:1])
				imucc_pkg::ADDR_AUX_DAC[6:1]: rd_data = {4'h0, dac_r};
				imucc_pkg::ADDR_MISC[6:1]: rd_data = misc_r;
				imucc_pkg::ADDR_PRD[6:1]: rd_data = prd_r;
				imucc_pkg::ADDR_DIAG[6:1]: rd_data = diag_flags;
				imucc_pkg::ADDR_PROD_ID[6:1]: rd_data = PROD_ID;
				default: rd_data = 16'h0000;
			endcase
		end
	end

	// Serial shifter: sample on rising edge, shift out on falling edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sclk_q_r <= 1'b1;
			cs_q_r <= 1'b1;
			bit_cnt_r <= 5'd0;
			rx_r <= 16'h0000;
			tx_r <= 16'h0000;
			spi_miso <= 1'b0;
		end else if (ce) begin
			sclk_q_r <= spi_sclk;
			cs_q_r <= spi_cs_n;
			if (cs_fall) begin
				bit_cnt_r <= 5'd0;
				tx_r <= tx_next_r;
				spi_miso <= tx_next_r[15];
			end else if (rise) begin
				rx_r <= word;
				if (frame_done) begin
					bit_cnt_r <= burst_r ? 5'd16 : 5'd0;
				end else if (bit_cnt_r == 5'd16) begin
					bit_cnt_r <= 5'd0;
				end else begin
					bit_cnt_r <= bit_cnt_r + 5'd1;
				end
			end else if (fall) begin
				if (bit_cnt_r == 5'd0) begin
					tx_r <= tx_next_r;
					spi_miso <= tx_next_r[15];
				end else begin
					tx_r <= {tx_r[14:0], 1'b0};
					spi_miso <= tx_r[14];
				end
			end
		end
	end

	// Reply queue and burst sequencing; reading the command register starts a burst
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tx_next_r <= 16'h0000;
			burst_r <= 1'b0;
			burst_idx_r <= 4'h0;
		end else if (ce) begin
			if (spi_cs_n) begin
				burst_r <= 1'b0;
			end else if (frame_done && burst_r) begin
				if (burst_idx_r == 4'(imucc_pkg::NUM_OUT - 1)) begin
					burst_r <= 1'b0;
					tx_next_r <= 16'h0000;
				end else begin
					burst_idx_r <= burst_idx_r + 4'h1;
					tx_next_r <= out_word(int'(burst_idx_r) + 1);
				end
			end else if (is_rd && wa == imucc_pkg::ADDR_CMD) begin
				burst_r <= 1'b1;
				burst_idx_r <= 4'h0;
				tx_next_r <= out_word(0);
			end else if (is_rd) begin
				tx_next_r <= rd_data;
			end else if (frame_done) begin
				tx_next_r <= 16'h0000;
			end
		end
	end

	// New-data flags cleared as each word is queued for the host
	always_comb begin
		nd_clr = 11'h000;
		if (frame_done && burst_r && burst_idx_r != 4'(imucc_pkg::NUM_OUT - 1)) begin
			nd_clr[burst_idx_r + 4'h1] = 1'b1;
		end else if (is_rd && wa == imucc_pkg::ADDR_CMD) begin
			nd_clr[0] = 1'b1;
		end else if (is_rd && wa >= imucc_pkg::ADDR_SUPPLY
				&& wa <= imucc_pkg::ADDR_AUX_ADC + 7'h01) begin
			nd_clr[4'((wa - imucc_pkg::ADDR_SUPPLY) >> 1)] = 1'b1;
		end
	end

	// Command decode in priority order, taken only while running
	assign go_boot = (state_r == imucc_pkg::ST_RUN) & cmd_r[imucc_pkg::CMD_SW_RESET];
	assign go_restore = (state_r == imucc_pkg::ST_RUN) & ~go_boot & cmd_r[imucc_pkg::CMD_RESTORE];
	assign go_null = (state_r == imucc_pkg::ST_RUN) & ~go_boot & ~go_restore
		& cmd_r[imucc_pkg::CMD_AUTONULL];
	assign go_prec = (state_r == imucc_pkg::ST_RUN) & ~go_boot & ~go_restore & ~go_null
		& cmd_r[imucc_pkg::CMD_PRECISION];
	assign go_flash = (state_r == imucc_pkg::ST_RUN) & ~go_boot & ~go_restore & ~go_null
		& ~go_prec & cmd_r[imucc_pkg::CMD_FLASH];
	assign go_sleep = (state_r == imucc_pkg::ST_RUN) & ~(|(cmd_r & imucc_pkg::CMD_VALID
		& ~(8'h01 << imucc_pkg::CMD_DAC_LATCH))) & (slp_inf_r | (sleep_control_r != 8'h00));
	assign prec_done = (state_r == imucc_pkg::ST_PREC) & (cnt_r == 32'h0000_0000);
	assign zero_out = go_restore | go_null | prec_done | go_boot;
	assign fsm_done = ((state_r == imucc_pkg::ST_SAVE) & flash_done)
		| ((state_r == imucc_pkg::ST_BOOT) & (cnt_r == 32'h0000_0000));

	// Sequencer for long operations and sleep
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= imucc_pkg::ST_RUN;
			cnt_r <= 32'h0000_0000;
			mask_r <= 8'h00;
			save_req_r <= 1'b0;
			slp_inf_r <= 1'b0;
			sleep_control_r <= 8'h00;
			sleep_left_r <= 8'h00;
			sleeping <= 1'b0;
		end else if (ce) begin
			save_req_r <= go_restore | go_null | go_flash | prec_done;
			if (is_wr && wa == imucc_pkg::ADDR_SLEEP_HI && wd[0]) begin
				slp_inf_r <= 1'b1;
			end else if (go_sleep) begin
				slp_inf_r <= 1'b0;
			end
			if (is_wr && wa == imucc_pkg::ADDR_SLEEP) begin
				sleep_control_r <= wd;
			end else if (go_sleep) begin
				sleep_control_r <= 8'h00;
			end
			case (state_r)
				imucc_pkg::ST_RUN: begin
					if (go_boot) begin
						state_r <= imucc_pkg::ST_BOOT;
						cnt_r <= imucc_pkg::BOOT_CYC;
						mask_r <= 8'h01 << imucc_pkg::CMD_SW_RESET;
					end else if (go_restore || go_null || go_flash) begin
						state_r <= imucc_pkg::ST_SAVE;
						mask_r <= {4'b0000, go_flash, 1'b0, go_restore, go_null};
					end else if (go_prec) begin
						state_r <= imucc_pkg::ST_PREC;
						cnt_r <= PREC_CYC - 32'h0000_0001;
						mask_r <= 8'h01 << imucc_pkg::CMD_PRECISION;
					end else if (go_sleep) begin
						state_r <= imucc_pkg::ST_SLEEP;
						sleeping <= 1'b1;
						sleep_left_r <= slp_inf_r ? 8'h00 : sleep_control_r;
						cnt_r <= SLEEP_UNIT - 32'h0000_0001;
					end
				end
				imucc_pkg::ST_PREC: begin
					if (prec_done) begin
						state_r <= imucc_pkg::ST_SAVE;
					end else begin
						cnt_r <= cnt_r - 32'h0000_0001;
					end
				end
				imucc_pkg::ST_SAVE, imucc_pkg::ST_BOOT: begin
					if (fsm_done) begin
						state_r <= imucc_pkg::ST_RUN;
					end else if (state_r == imucc_pkg::ST_BOOT) begin
						cnt_r <= cnt_r - 32'h0000_0001;
					end
				end
				imucc_pkg::ST_SLEEP: begin
					if (sleep_left_r == 8'h00) begin
						if (cs_fall) begin
							state_r <= imucc_pkg::ST_RUN;
							sleeping <= 1'b0;
						end
					end else if (cnt_r == 32'h0000_0000) begin
						cnt_r <= SLEEP_UNIT - 32'h0000_0001;
						if (sleep_left_r == 8'h01) begin
							state_r <= imucc_pkg::ST_RUN;
							sleeping <= 1'b0;
						end
						sleep_left_r <= sleep_left_r - 8'h01;
					end else begin
						cnt_r <= cnt_r - 32'h0000_0001;
					end
				end
				default: begin
					state_r <= imucc_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Command bits: host sets, completion clears, a new set wins
	always_comb begin
		cmd_clr = fsm_done ? mask_r : 8'h00;
		cmd_clr[imucc_pkg::CMD_DAC_LATCH] = cmd_r[imucc_pkg::CMD_DAC_LATCH];
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmd_r <= 8'h00;
		end else if (ce) begin
			if (is_wr && wa == imucc_pkg::ADDR_CMD) begin
				cmd_r <= (cmd_r & ~cmd_clr) | (wd & imucc_pkg::CMD_VALID);
			end else begin
				cmd_r <= cmd_r & ~cmd_clr;
			end
		end
	end

	// Control registers: reload, restore, autonull loads and byte writes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < 6; i++) begin
				offs_r[i] <= 16'h0000;
			end
			misc_r <= imucc_pkg::MISC_RESET;
			prd_r <= imucc_pkg::PRD_RESET;
			dac_r <= 12'h000;
		end else if (ce) begin
			if (go_boot) begin
				for (int i = 0; i < 6; i++) begin
					offs_r[i] <= nv_q.offs[i];
				end
				misc_r <= nv_q.misc;
				prd_r <= nv_q.prd;
			end else if (go_restore) begin
				for (int i = 0; i < 6; i++) begin
					offs_r[i] <= 16'h0000;
				end
			end else if (go_null) begin
				for (int i = 0; i < 3; i++) begin
					offs_r[i] <= neg_off({raw.gyro[i], 2'b00});
				end
			end else if (prec_done) begin
				for (int i = 0; i < 3; i++) begin
					offs_r[i] <= neg_off(avg_r[i]);
				end
			end else if (is_wr) begin
				for (int i = 0; i < 6; i++) begin
					if (wa[6:1] == 6'(imucc_pkg::ADDR_GYRO_OFF[6:1] + i)) begin
						offs_r[i] <= (wa[0] ? {wd, offs_r[i][7:0]} : {offs_r[i][15:8], wd})
							& (i < 3 ? imucc_pkg::GYRO_OFF_MASK
							: imucc_pkg::ACCL_OFF_MASK);
					end
				end
				case (wa)
					imucc_pkg::ADDR_MISC: misc_r[7:0] <= wd;
					imucc_pkg::ADDR_MISC + 7'h01: misc_r[15:8] <= wd & 8'h0F;
					imucc_pkg::ADDR_PRD: prd_r[7:0] <= wd;
					imucc_pkg::ADDR_AUX_DAC: dac_r[7:0] <= wd;
					imucc_pkg::ADDR_AUX_DAC + 7'h01: dac_r[11:8] <= wd[3:0];
					default: dac_r <= dac_r;
				endcase
			end
		end
	end

	// DAC latch moves both bytes together; low power follows the period value
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dac_value <= 12'h000;
			low_power <= 1'b0;
		end else if (ce) begin
			if (cmd_r[imucc_pkg::CMD_DAC_LATCH]) begin
				dac_value <= dac_r;
			end
			low_power <= (prd_r[7:0] >= imucc_pkg::LOW_POWER_MIN);
		end
	end

	// Gyro averaging during the offline window, in quarter-count units
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < 3; i++) begin
				avg_r[i] <= 16'h0000;
			end
		end else if (ce) begin
			for (int i = 0; i < 3; i++) begin
				if (go_prec) begin
					avg_r[i] <= {raw.gyro[i], 2'b00};
				end else if (tick && state_r == imucc_pkg::ST_PREC) begin
					avg_r[i] <= avg_r[i] + 16'(($signed({raw.gyro[i], 2'b00})
						- $signed(avg_r[i])) >>> imucc_pkg::AVG_SHIFT);
				end
			end
		end
	end

	// Output words: latched per sample while running, zeroed by calibration
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < imucc_pkg::NUM_OUT; i++) begin
				out_r[i] <= 14'h0000;
			end
			nd_r <= 11'h000;
		end else if (ce) begin
			if (zero_out) begin
				for (int i = 0; i < imucc_pkg::NUM_OUT; i++) begin
					out_r[i] <= 14'h0000;
				end
				nd_r <= 11'h000;
			end else if (tick && state_r == imucc_pkg::ST_RUN) begin
				out_r[0] <= {2'b00, raw.supply};
				for (int i = 0; i < 3; i++) begin
					out_r[1 + i] <= gyro_adj(raw.gyro[i], offs_r[i], raw.accel[i],
						misc_r[imucc_pkg::MISC_LIN_COMP]);
					out_r[4 + i] <= raw.accel[i]
						+ {{2{offs_r[3 + i][11]}}, offs_r[3 + i][11:0]};
					out_r[7 + i] <= {2'b00, raw.temp[i]};
				end
				out_r[10] <= {2'b00, raw.aux};
				nd_r <= 11'h7FF;
			end else begin
				nd_r <= nd_r & ~nd_clr;
			end
		end
	end

	// Image handed to the flash copy
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			nv_img.offs[i] = offs_r[i];
		end
		nv_img.misc = misc_r;
		nv_img.prd = prd_r;
	end

	// Flash copy of the control registers
	imucc_nvmem #(
		.FLASH_CYC(FLASH_CYC)
	) u_nvmem (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.save(save_req_r),
		.wdata(nv_img),
		.rdata(nv_q),
		.done(flash_done)
	);

	// Sample period generator; runs while sensing or averaging
	imucc_tick #(
		.TB_FAST(TB_FAST),
		.TB_SLOW(TB_SLOW)
	) u_tick (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.run(state_r == imucc_pkg::ST_RUN || state_r == imucc_pkg::ST_PREC),
		.period(prd_r[7:0]),
		.tick(tick)
	);

	// Registered copy of the sample strobe for the sensing core
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sample_tick <= 1'b0;
		end else if (ce) begin
			sample_tick <= tick;
		end
	end
endmodule : imucc_ctrl
`default_nettype wire

/* File: shared/imucc_pkg.sv */
// Package for the inertial sensor calibration and command control block
package imucc_pkg;
	// Clock and timing constants (times in ns, cycles derived)
	localparam longint CLK_PERIOD_NS = 64'd8;
	localparam longint TB_FAST_NS = 64'd610350; // 0.61035 ms
	localparam longint TB_SLOW_NS = 64'd18921000; // 18.921 ms
	localparam longint FLASH_MAX_NS = 64'd50000000; // 50 ms, longest time
	localparam longint PREC_NS = 64'd30000000000; // 30 s offline window
	localparam longint SLEEP_UNIT_NS = 64'd500000000; // 0.5 s per count
	localparam longint TB_FAST_CYC = TB_FAST_NS / CLK_PERIOD_NS;
	localparam longint TB_SLOW_CYC = TB_SLOW_NS / CLK_PERIOD_NS;
	localparam longint FLASH_CYC = FLASH_MAX_NS / CLK_PERIOD_NS;
	localparam longint PREC_CYC = PREC_NS / CLK_PERIOD_NS;
	localparam longint SLEEP_UNIT_CYC = SLEEP_UNIT_NS / CLK_PERIOD_NS;
	localparam logic [31:0] BOOT_CYC = 32'h0000_0010;

	// Byte addresses of the register map (lower byte shown)
	localparam logic [6:0] ADDR_SUPPLY = 7'h02;
	localparam logic [6:0] ADDR_AUX_ADC = 7'h16;
	localparam logic [6:0] ADDR_GYRO_OFF = 7'h1A;
	localparam logic [6:0] ADDR_ACCL_OFF_END = 7'h25;
	localparam logic [6:0] ADDR_AUX_DAC = 7'h30;
	localparam logic [6:0] ADDR_MISC = 7'h34;
	localparam logic [6:0] ADDR_PRD = 7'h36;
	localparam logic [6:0] ADDR_SLEEP = 7'h3A;
	localparam logic [6:0] ADDR_SLEEP_HI = 7'h3B;
	localparam logic [6:0] ADDR_DIAG = 7'h3C;
	localparam logic [6:0] ADDR_CMD = 7'h3E;
	localparam logic [6:0] ADDR_PROD_ID = 7'h56;

	// Reset values and field positions
	localparam logic [15:0] MISC_RESET = 16'h0006;
	localparam logic [15:0] PRD_RESET = 16'h0001;
	localparam logic [7:0] LOW_POWER_MIN = 8'h0A;
	localparam int MISC_LIN_COMP = 7;
	localparam int PRD_TB_SEL = 7;
	localparam int CMD_AUTONULL = 0;
	localparam int CMD_RESTORE = 1;
	localparam int CMD_DAC_LATCH = 2;
	localparam int CMD_FLASH = 3;
	localparam int CMD_PRECISION = 4;
	localparam int CMD_SW_RESET = 7;
	localparam logic [7:0] CMD_VALID = 8'h9F;
	localparam logic [15:0] GYRO_OFF_MASK = 16'h1FFF;
	localparam logic [15:0] ACCL_OFF_MASK = 16'h0FFF;
	localparam logic [15:0] DAC_MASK = 16'h0FFF;
	localparam int NUM_OUT = 11;
	localparam int AVG_SHIFT = 4;

	// Raw sensor samples from the sensing core
	typedef struct packed {
		logic [11:0] supply;
		logic [2:0][13:0] gyro;
		logic [2:0][13:0] accel;
		logic [2:0][11:0] temp;
		logic [11:0] aux;
	} imucc_raw_t;

	// Nonvolatile control image: six offsets, misc control, sample period
	typedef struct packed {
		logic [5:0][15:0] offs;
		logic [15:0] misc;
		logic [15:0] prd;
	} imucc_nv_t;

	// Control sequencer states
	typedef enum logic [5:0] {
		ST_RUN = 6'b000001,
		ST_SAVE = 6'b000010,
		ST_BOOT = 6'b000100,
		ST_PREC = 6'b001000,
		ST_SLEEP = 6'b010000,
		ST_IDLE = 6'b100000
	} imucc_state_t;
endpackage : imucc_pkg

/* File: verilog/imucc_nvmem.sv */
// Flash copy of the nonvolatile control registers with a timed commit
`timescale 1ns/100ps
`default_nettype none
module imucc_nvmem #(
	parameter logic [31:0] FLASH_CYC = 32'(imucc_pkg::FLASH_CYC)
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic save, // Commit request pulse
	input wire imucc_pkg::imucc_nv_t wdata, // Image to store
	output imucc_pkg::imucc_nv_t rdata, // Stored image
	output logic done // Commit finished pulse
);
	logic [15:0] mem_r [0:7];
	logic [31:0] cnt_r;
	logic busy_r;

	// Image is captured at once; done fires after the programming time
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			for (int i = 0; i < 6; i++) begin
				mem_r[i] <= 16'h0000;
			end
			mem_r[6] <= imucc_pkg::MISC_RESET;
			mem_r[7] <= imucc_pkg::PRD_RESET;
			busy_r <= 1'b0;
			cnt_r <= 32'h0000_0000;
			done <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			if (save) begin
				for (int i = 0; i < 6; i++) begin
					mem_r[i] <= wdata.offs[i];
				end
				mem_r[6] <= wdata.misc;
				mem_r[7] <= wdata.prd;
				busy_r <= 1'b1;
				cnt_r <= FLASH_CYC - 32'h0000_0001;
			end else if (busy_r) begin
				if (cnt_r == 32'h0000_0000) begin
					busy_r <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_r <= cnt_r - 32'h0000_0001;
				end
			end
		end
	end

	// Read side of the stored image
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			rdata.offs[i] = mem_r[i];
		end
		rdata.misc = mem_r[6];
		rdata.prd = mem_r[7];
	end
endmodule : imucc_nvmem
`default_nettype wire

/* File: verilog/imucc_tick.sv */
// Internal sample period generator
`timescale 1ns/100ps
`default_nettype none
module imucc_tick #(
	parameter logic [31:0] TB_FAST = 32'(imucc_pkg::TB_FAST_CYC),
	parameter logic [31:0] TB_SLOW = 32'(imucc_pkg::TB_SLOW_CYC)
) (
	input wire logic clk_sys, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic run, // Sampling allowed
	input wire logic [7:0] period, // Time base select and increment
	output logic tick // One-cycle sample strobe
);
	logic [31:0] base_r;
	logic [6:0] inc_r;
	logic [31:0] base_max;

	assign base_max = (period[imucc_pkg::PRD_TB_SEL] ? TB_SLOW : TB_FAST) - 32'h0000_0001;

	// Period is time base times increment plus one; restarts when halted
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			base_r <= 32'h0000_0000;
			inc_r <= 7'h00;
			tick <= 1'b0;
		end else if (ce) begin
			tick <= 1'b0;
			if (!run) begin
				base_r <= 32'h0000_0000;
				inc_r <= 7'h00;
			end else if (base_r >= base_max) begin
				base_r <= 32'h0000_0000;
				if (inc_r >= period[6:0]) begin
					inc_r <= 7'h00;
					tick <= 1'b1;
				end else begin
					inc_r <= inc_r + 7'h01;
				end
			end else begin
				base_r <= base_r + 32'h0000_0001;
			end
		end
	end
endmodule : imucc_tick
`default_nettype wire

/* File: dv/imucc_monitor.sv */
// Port checker of the command control block
`timescale 1ns/100ps
`default_nettype none
module imucc_monitor (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic spi_cs_n, // Select
	input wire logic spi_sclk, // Serial clock
	input wire logic spi_miso, // Data out
	input wire logic sample_tick, // Strobe
	input wire logic [11:0] dac_value, // DAC
	input wire logic low_power, // Power mode
	input wire logic sleeping // Asleep
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Settled sleep skips the first two sleeping cycles; six idle clock samples skip the load lag
	sequence s_nap; sleeping [*3]; endsequence
	sequence s_rest; (spi_sclk && !spi_cs_n) [*6]; endsequence
	// Outputs tied to their causes
	reset_clear_a: assert property ($fell(rst) |-> !sleeping && !low_power && !spi_miso)
		else $error("reset left an output set");
	tick_pulse_a: assert property (sample_tick |=> !sample_tick [*3])
		else $error("strobe too soon");
	tick_period_a: assert property (sample_tick && !low_power |->
		##[1:400] (sample_tick || sleeping || low_power)) else $error("strobe missing");
	sleep_quiet_a: assert property (s_nap |-> !sample_tick)
		else $error("strobe in sleep");
	dac_sleep_a: assert property (s_nap |-> $stable(dac_value))
		else $error("DAC moved in sleep");
	mode_sleep_a: assert property (s_nap |-> $stable(low_power))
		else $error("mode moved in sleep");
	wake_select_a: assert property (sleeping && $fell(spi_cs_n) |-> ##[1:8] !sleeping)
		else $error("no wake on select");
	miso_hold_a: assert property (s_rest |-> $stable(spi_miso))
		else $error("data moved with clock high");
endmodule : imucc_monitor
bind imucc_ctrl imucc_monitor u_mon (.clk_sys, .rst, .spi_cs_n, .spi_sclk, .spi_miso,
	.sample_tick, .dac_value, .low_power, .sleeping);
`default_nettype wire

/* File: dv/imucc_host_model.sv */
// Host processor model on the mode 3 serial port
`timescale 1ns/100ps
`default_nettype none
module imucc_host_model (
	input wire logic clk_sys, // Clock
	output logic spi_cs_n, // Select
	output logic spi_sclk, // Serial clock
	output logic spi_mosi, // Data to device
	input wire logic spi_miso // Data from device
);
	// Idle: deselected, clock high
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b1;
		spi_mosi = 1'b0;
	end
	// Slow levels give the device time to see both edges
	task automatic half();
		repeat (6) @(posedge clk_sys);
		#1;
	endtask : half
	// One word msb first; a read or burst answers in the next word
	task automatic frame(input logic [15:0] w, input logic keep, input logic gap,
		output logic [15:0] rx);
		spi_cs_n = 1'b0; // Select fall also wakes a device in indefinite sleep
		for (int i = 0; i < 16 + gap; i++) begin
			half();
			spi_sclk = 1'b0;
			spi_mosi = i < 16 ? w[15 - i] : ~spi_mosi;
			half();
			spi_sclk = 1'b1;
			if (i < 16)
				rx[15 - i] = spi_miso;
		end
		half();
		// Deselect stands a while so the next frame sees a fresh select fall
		if (!keep) begin
			spi_cs_n = 1'b1;
			half();
		end
		spi_mosi = ~spi_mosi; // Released line toggles so no stale bit survives
	endtask : frame
endmodule : imucc_host_model
`default_nettype wire

/* File: dv/imu_calibration_command_control_tb_top.sv */
// Bench of the command control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
	$display("FAIL %0t %h %h", $time, a, e); end end
module imu_calibration_command_control_tb_top;
	logic clk_sys, rst, ce, spi_cs_n, spi_sclk, spi_mosi, spi_miso, low_power, sleeping;
	logic [11:0] dac_value;
	logic [15:0] r, diag;
	imucc_pkg::imucc_raw_t raw; // Sensing core stand-in, rate changed for the calibration test
	// Burst words: supply, rate, accel, temp, aux, new-data and error set
	logic [15:0] bw [5] = '{16'hC814, 16'hFFFF, 16'hD519, 16'hCE22, 16'hC4D9};
	int miscompares, checked;
	// Short counts keep timed operations brief
	imucc_ctrl #(.TB_FAST(32'h4), .TB_SLOW(32'h8), .FLASH_CYC(32'h14), .PREC_CYC(32'hC8),
		.SLEEP_UNIT(32'h32)) u_dut (.clk_sys, .rst, .ce, .spi_cs_n, .spi_sclk, .spi_mosi,
		.spi_miso, .raw, .diag_flags(diag), .sample_tick(), .dac_value, .low_power, .sleeping);
	imucc_host_model u_host (.clk_sys, .spi_cs_n, .spi_sclk, .spi_mosi, .spi_miso);
	// 125 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Word helpers; a read answers in the following word
	task automatic wr(input logic [15:0] w);
		u_host.frame(w, 1'b0, 1'b0, r);
	endtask : wr
	task automatic rd(input logic [6:0] a, input logic [15:0] e);
		wr({1'b0, a, 8'h00});
		wr(16'h0000);
		`CHK(r, e)
	endtask : rd
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : idle
	// Verdict, the only exit
	task automatic close_out();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	// Watchdog far past the expected run
	initial begin
		#400000;
		miscompares++;
		close_out();
	end
	// Burst, offsets, power and flash, DAC and sleep
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		diag = 16'h0004;
		raw = {12'h814, {3{14'h3FFF}}, {3{14'h1519}}, {3{12'hE22}}, 12'h4D9};
		idle(8);
		rst = 1'b0;
		u_host.frame(16'h3E00, 1'b1, 1'b0, r);
		for (int k = 0; k < 11; k++) begin
			u_host.frame(16'h0000, k < 10, 1'b1, r);
			`CHK(r, bw[(k + 2) / 3])
		end
		$display("burst done");
		wr(16'h9BFF);
		wr(16'h9AF6);
		rd(7'h1A, 16'h1FF6);
		wr(16'hA1FF);
		wr(16'hA0F6);
		rd(7'h20, 16'h0FF6);
		wr(16'hBE02);
		rd(7'h20, 16'h0000);
		wr(16'hBE01);
		rd(7'h1A, 16'h0004);
		$display("offsets done");
		wr(16'hB60A);
		`CHK(low_power, 1'b1)
		wr(16'hBE80);
		rd(7'h36, 16'h0001);
		wr(16'hB60A);
		wr(16'hBE08);
		wr(16'hBE80);
		rd(7'h36, 16'h000A);
		wr(16'hB609);
		`CHK(low_power, 1'b0)
		$display("power done");
		wr(16'hB0D9);
		wr(16'hB104);
		`CHK(dac_value, 12'h000)
		wr(16'hBE04);
		`CHK(dac_value, 12'h4D9)
		wr(16'hBA02);
		idle(4);
		`CHK(sleeping, 1'b1)
		ce = 1'b0;
		idle(120);
		`CHK(sleeping, 1'b1)
		ce = 1'b1;
		idle(120);
		`CHK(sleeping, 1'b0)
		wr(16'hBB01);
		idle(200);
		`CHK(sleeping, 1'b1)
		wr(16'h0000);
		`CHK(sleeping, 1'b0)
		$display("sleep done");
		// Precision null of a new rate, then the acceleration term on the rate word
		raw.gyro = {3{14'h0010}};
		diag = 16'h0000;
		wr(16'hBE10);
		idle(100);
		rd(7'h1A, 16'h1FC0);
		rd(7'h04, 16'h8000);
		wr(16'hB486);
		rd(7'h04, 16'hBEAE);
		$display("calibration done");
		close_out();
	end
endmodule : imu_calibration_command_control_tb_top
`default_nettype wire
